/* File: design/usc_pkg.sv */
// Shared constants and types for the serial engine control block
package usc_pkg;

  // ==========================================================
  // Link between controller end and device end
  // ==========================================================
  typedef logic [7:0] usc_byte_t;
  typedef logic [2:0] usc_idx_t;

  // Register indices on the link
  localparam usc_idx_t IDX_CLKCTL = 3'h0;
  localparam usc_idx_t IDX_ADDR = 3'h1;
  localparam usc_idx_t IDX_OSTALL = 3'h2;
  localparam usc_idx_t IDX_ISTALL = 3'h3;
  localparam usc_idx_t IDX_STATUS = 3'h4;

  localparam int unsigned EP_MAX = 8;
  localparam int unsigned EP_NARROW = 4;
  localparam usc_byte_t REG_RESET = 8'h00;

  // ==========================================================
  // usb_clock_fifo_select_control fields
  // ==========================================================
  localparam int CLK_PULLUP = 7;
  localparam int CLK_OSC = 6;
  localparam int CLK_PLL = 5;
  localparam int CLK_SUSP = 4;
  localparam int CLK_EN = 3;
  localparam int FSEL_W = 3;
  localparam usc_byte_t CLK_WMASK_WIDE = 8'hFF;
  localparam usc_byte_t CLK_WMASK_NARROW = 8'hFB;

  // ==========================================================
  // device_address_wake and serial_engine_status fields
  // ==========================================================
  localparam int ADDR_WAKE = 0;
  localparam int ADDR_W = 7;
  localparam int STS_NAKMASK = 7;
  localparam int STS_RXERR = 6;
  localparam int STS_NORESP = 4;
  localparam int STS_IN = 3;
  localparam int STS_OUT = 2;
  localparam int STS_FIFOERR = 1;
  localparam int STS_UPDMODE = 0;
  // Flags written as one keep their value
  localparam logic [6:0] STS_KEEP_FLAGS = 7'h7E;

  // ==========================================================
  // Controller APB map
  // ==========================================================
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CMD = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STAT = 8'h04;
  localparam int CMD_IDX_LSB = 0;
  localparam int CMD_WD_LSB = 8;
  localparam int CMD_WRITE = 16;
  localparam int CMD_START = 31;
  localparam int STAT_BUSY = 0;
  localparam int STAT_HOLD = 1;
  localparam int STAT_RD_LSB = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_WAIT = 2'b10
  } usc_ctl_state_t;

endpackage : usc_pkg

/* File: design/usc_link_if.sv */
// Register link between the firmware controller and the engine
`timescale 1ns/1ps
`default_nettype none
interface usc_link_if;
  logic wr;
  logic rd;
  usc_pkg::usc_idx_t idx;
  usc_pkg::usc_byte_t wdata;
  usc_pkg::usc_byte_t rdata;
  logic ack;

  modport device (input wr, rd, idx, wdata, output rdata, ack);
  modport ctrl (output wr, rd, idx, wdata, input rdata, ack);
endinterface : usc_link_if
`default_nettype wire

/* File: design/usc_device.sv */
// Engine end: control, address, stall and status registers
//
// Behaviour
// - Eight endpoints: select codes map ascending
// - Six endpoints: codes 101..111 pick endpoint 5
// - Control bit connects data-plus pull-up resistor
// - Firmware sets oscillator bit per crystal
// - Clock source bit chooses oscillator or PLL
// - Suspend bit enters low-power halt mode
// - Engine clock enable gates engine clock
// - Address in bits 7..1, wake bit 0
// - Wake bit enables remote wake-up
// - Firmware loads address after setup stage
// - Per-endpoint OUT stall bits, set on fault
// - Per-endpoint IN stall bits, set on fault
// - Bus reset or setup clears stall bits
// - NAK mask bit suppresses NAK interrupt
// - Receive error flag sticky until cleared
// - No-response error flag sticky until cleared
// - Read-only bit shows current IN token
// - OUT flag set on data-bearing OUT token
// - Next valid setup clears OUT flag
// - FIFO access error flag sticky until cleared
// - Address update immediate or after IN read
// - Firmware clears update mode after setup
`timescale 1ns/1ps
`default_nettype none
module usc_device #(
  parameter int unsigned ENDPOINTS = usc_pkg::EP_MAX
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  usc_link_if.device link,
  input wire logic i_usb_bus_reset,
  input wire logic i_setup_token,
  input wire logic i_in_token,
  input wire logic i_out_data_token,
  input wire logic i_crc_error,
  input wire logic i_pid_error,
  input wire logic i_stuff_error,
  input wire logic i_no_response_error,
  input wire logic i_fifo_access_error,
  input wire logic i_nak_sent,
  input wire logic i_in_read_ok,
  input wire usc_pkg::usc_byte_t i_ep_out_fault,
  input wire usc_pkg::usc_byte_t i_ep_in_fault,
  output logic o_usb_data_plus_pullup,
  output logic o_oscillator_freq_select,
  output logic o_system_clock_from_pll,
  output logic o_suspend_halt_enable,
  output logic o_usb_engine_clock_enable,
  output logic [usc_pkg::FSEL_W-1:0] o_fifo_endpoint,
  output logic [usc_pkg::ADDR_W-1:0] o_device_address,
  output logic o_remote_wake_enable,
  output logic o_nak_interrupt,
  output usc_pkg::usc_byte_t o_out_stall_bits,
  output usc_pkg::usc_byte_t o_in_stall_bits
);
  import usc_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic usc_byte_t ep_mask(input int unsigned n);
    usc_byte_t m;
    m = REG_RESET;
    for (int i = 0; i < EP_MAX; i++) begin
      if (i < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : ep_mask

  // Codes past the last endpoint fold onto it
  function automatic logic [FSEL_W-1:0] fifo_ep(
    input logic [FSEL_W-1:0] sel, input int unsigned n);
    logic [FSEL_W-1:0] last;
    last = FSEL_W'(n - 1);
    if (sel >= last) begin
      return last;
    end
    return sel;
  endfunction : fifo_ep

  function automatic usc_byte_t stall_next(input usc_byte_t cur,
    input logic wr, input usc_byte_t wd, input logic clr,
    input usc_byte_t fault, input usc_byte_t mask);
    usc_byte_t v;
    v = wr ? wd : cur;
    if (clr) begin
      v = REG_RESET;
    end
    return (v | fault) & mask;
  endfunction : stall_next

  // Writing one keeps a flag, zero clears it; a set wins
  function automatic logic flag_next(input logic cur, input logic wr,
    input logic wbit, input logic set);
    return set | (cur & ~(wr & ~wbit));
  endfunction : flag_next

  localparam usc_byte_t IMPL = ep_mask(ENDPOINTS);
  localparam usc_byte_t CLK_WMASK =
    (ENDPOINTS > EP_NARROW) ? CLK_WMASK_WIDE : CLK_WMASK_NARROW;

  logic wr_clkctl;
  logic wr_addr;
  logic wr_ostall;
  logic wr_istall;
  logic wr_status;
  usc_byte_t clkctl;
  usc_byte_t addr_reg;
  logic addr_pending;
  logic nak_mask;
  logic crc_flag;
  logic noresp_flag;
  logic in_now;
  logic out_flag;
  logic fifo_err_flag;
  logic addr_mode;
  logic stall_clear;
  usc_byte_t serial_engine_status_view;
  usc_byte_t next_out_stall;
  usc_byte_t next_in_stall;

  assign wr_clkctl = link.wr && (link.idx == IDX_CLKCTL);
  assign wr_addr = link.wr && (link.idx == IDX_ADDR);
  assign wr_ostall = link.wr && (link.idx == IDX_OSTALL);
  assign wr_istall = link.wr && (link.idx == IDX_ISTALL);
  assign wr_status = link.wr && (link.idx == IDX_STATUS);

  // ==========================================================
  // Clock, pull-up and FIFO select control
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      clkctl <= REG_RESET;
    end else if (wr_clkctl) begin
      clkctl <= link.wdata & CLK_WMASK;
    end
  end

  // Outputs lag the register by one cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_usb_data_plus_pullup <= 1'b0;
      o_oscillator_freq_select <= 1'b0;
      o_system_clock_from_pll <= 1'b0;
      o_suspend_halt_enable <= 1'b0;
      o_usb_engine_clock_enable <= 1'b0;
      o_fifo_endpoint <= '0;
    end else begin
      o_usb_data_plus_pullup <= clkctl[CLK_PULLUP];
      o_oscillator_freq_select <= clkctl[CLK_OSC];
      o_system_clock_from_pll <= clkctl[CLK_PLL];
      o_suspend_halt_enable <= clkctl[CLK_SUSP];
      o_usb_engine_clock_enable <= clkctl[CLK_EN];
      o_fifo_endpoint <= fifo_ep(clkctl[FSEL_W-1:0], ENDPOINTS);
    end
  end

  // ==========================================================
  // Device address and remote wake-up
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      addr_reg <= REG_RESET;
      o_remote_wake_enable <= 1'b0;
    end else begin
      if (wr_addr) begin
        addr_reg <= link.wdata;
      end
      o_remote_wake_enable <= addr_reg[ADDR_WAKE];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_device_address <= '0;
      addr_pending <= 1'b0;
    end else if (wr_addr) begin
      if (!addr_mode) begin
        o_device_address <= link.wdata[ADDR_W:1];
        addr_pending <= 1'b0;
      end else begin
        addr_pending <= 1'b1;
      end
    end else if (addr_pending && i_in_read_ok) begin
      o_device_address <= addr_reg[ADDR_W:1];
      addr_pending <= 1'b0;
    end
  end

  // ==========================================================
  // Stall bits
  // ==========================================================
  // bus reset or setup clears
  assign stall_clear = i_usb_bus_reset | i_setup_token;

  always_comb begin
    // OUT stall write and fault set
    next_out_stall = stall_next(o_out_stall_bits, wr_ostall, link.wdata,
      stall_clear, i_ep_out_fault, IMPL);
    // IN stall write and fault set
    next_in_stall = stall_next(o_in_stall_bits, wr_istall, link.wdata,
      stall_clear, i_ep_in_fault, IMPL);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_out_stall_bits <= REG_RESET;
      o_in_stall_bits <= REG_RESET;
    end else begin
      o_out_stall_bits <= next_out_stall;
      o_in_stall_bits <= next_in_stall;
    end
  end

  // ==========================================================
  // Engine status
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      nak_mask <= 1'b0;
      addr_mode <= 1'b0;
      crc_flag <= 1'b0;
      noresp_flag <= 1'b0;
      fifo_err_flag <= 1'b0;
      out_flag <= 1'b0;
      in_now <= 1'b0;
    end else begin
      if (wr_status) begin
        nak_mask <= link.wdata[STS_NAKMASK];
        addr_mode <= link.wdata[STS_UPDMODE];
      end
      crc_flag <= flag_next(crc_flag, wr_status, link.wdata[STS_RXERR],
        i_crc_error | i_pid_error | i_stuff_error);
      noresp_flag <= flag_next(noresp_flag, wr_status,
        link.wdata[STS_NORESP], i_no_response_error);
      fifo_err_flag <= flag_next(fifo_err_flag, wr_status,
        link.wdata[STS_FIFOERR], i_fifo_access_error);
      out_flag <= flag_next(out_flag & ~i_setup_token, wr_status,
        link.wdata[STS_OUT], i_out_data_token);
      in_now <= i_in_token;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_nak_interrupt <= 1'b0;
    end else begin
      o_nak_interrupt <= i_nak_sent & ~nak_mask;
    end
  end

  assign serial_engine_status_view = {nak_mask, crc_flag, 1'b0, noresp_flag, in_now,
    out_flag, fifo_err_flag, addr_mode};

  // ==========================================================
  // Link read-back
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      link.rdata <= REG_RESET;
      link.ack <= 1'b0;
    end else begin
      link.ack <= link.wr | link.rd;
      if (link.rd) begin
        unique case (link.idx)
          IDX_CLKCTL: link.rdata <= clkctl;
          IDX_ADDR: link.rdata <= addr_reg;
          IDX_OSTALL: link.rdata <= o_out_stall_bits;
          IDX_ISTALL: link.rdata <= o_in_stall_bits;
          IDX_STATUS: link.rdata <= serial_engine_status_view;
          default: link.rdata <= REG_RESET;
        endcase
      end
    end
  end

endmodule : usc_device
`default_nettype wire

/* File: design/usc_ctrl.sv */
// Firmware end: APB command port driving the engine register link
`timescale 1ns/1ps
`default_nettype none
module usc_ctrl (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [usc_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_setup_token,
  input wire logic i_setup_stage_done,
  input wire logic i_osc_is_6mhz,
  usc_link_if.ctrl link
);
  import usc_pkg::*;

  usc_ctl_state_t state;
  logic queued;
  usc_idx_t q_idx;
  usc_byte_t q_wdata;
  logic q_write;
  logic updmode_shadow;
  logic nmi_shadow;
  logic auto_clear;
  usc_byte_t last_rdata;
  logic busy;
  logic apb_setup;
  logic apb_access;
  logic cmd_start;
  logic hold_addr;
  logic issue_auto;
  logic issue_cmd;
  usc_byte_t cmd_wdata;

  assign busy = queued | (state != ST_IDLE);
  assign apb_setup = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable & o_pready;
  assign cmd_start = apb_access & i_pwrite & (i_paddr == OFS_CMD)
    & i_pwdata[CMD_START] & ~busy;
  // address load waits for setup stage end
  assign hold_addr = q_write & (q_idx == IDX_ADDR) & ~i_setup_stage_done;
  assign issue_auto = (state == ST_IDLE) & auto_clear;
  assign issue_cmd = (state == ST_IDLE) & ~auto_clear & queued
    & ~hold_addr;

  always_comb begin
    cmd_wdata = q_wdata;
    if (q_idx == IDX_CLKCTL) begin
      cmd_wdata[CLK_OSC] = i_osc_is_6mhz;
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= apb_setup;
      if (apb_setup) begin
        o_prdata <= '0;
        o_pslverr <= 1'b0;
        if (i_paddr == OFS_STAT) begin
          o_prdata[STAT_BUSY] <= busy;
          o_prdata[STAT_HOLD] <= (state == ST_HOLD);
          o_prdata[STAT_RD_LSB +: 8] <= last_rdata;
        end else if (i_paddr != OFS_CMD) begin
          o_pslverr <= 1'b1;
        end else if (i_pwrite && i_pwdata[CMD_START] && busy) begin
          // A start while busy is refused, not queued
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Command queue and shadows
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      queued <= 1'b0;
      q_idx <= IDX_CLKCTL;
      q_wdata <= REG_RESET;
      q_write <= 1'b0;
    end else if (cmd_start) begin
      queued <= 1'b1;
      q_idx <= i_pwdata[CMD_IDX_LSB +: 3];
      q_wdata <= i_pwdata[CMD_WD_LSB +: 8];
      q_write <= i_pwdata[CMD_WRITE];
    end else if (issue_cmd) begin
      queued <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      auto_clear <= 1'b0;
      updmode_shadow <= 1'b0;
      nmi_shadow <= 1'b0;
    end else begin
      if (issue_cmd && q_write && q_idx == IDX_STATUS) begin
        updmode_shadow <= q_wdata[STS_UPDMODE];
        nmi_shadow <= q_wdata[STS_NAKMASK];
      end else if (issue_auto) begin
        updmode_shadow <= 1'b0;
      end
      if (i_setup_token && updmode_shadow) begin
        auto_clear <= 1'b1;
      end else if (issue_auto) begin
        auto_clear <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Link sequencer
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      link.idx <= IDX_CLKCTL;
      link.wdata <= REG_RESET;
      last_rdata <= REG_RESET;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      unique case (state)
        ST_IDLE, ST_HOLD: begin
          if (issue_auto) begin
            link.wr <= 1'b1;
            link.idx <= IDX_STATUS;
            link.wdata <= {nmi_shadow, STS_KEEP_FLAGS};
            state <= ST_WAIT;
          end else if (state == ST_HOLD || (queued && hold_addr)) begin
            state <= hold_addr ? ST_HOLD : ST_IDLE;
          end else if (issue_cmd) begin
            link.wr <= q_write;
            link.rd <= ~q_write;
            link.idx <= q_idx;
            link.wdata <= cmd_wdata;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (link.ack) begin
            last_rdata <= link.rdata;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule : usc_ctrl
`default_nettype wire

/* File: sim/usc_link_monitor.sv */
// Handshake checker on the register link between the two ends
`timescale 1ns/1ps
`default_nettype none
module usc_link_monitor #(
  parameter int unsigned ENDPOINTS = usc_pkg::EP_MAX
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic wr,
  input wire logic rd,
  input wire usc_pkg::usc_idx_t idx,
  input wire usc_pkg::usc_byte_t wdata,
  input wire usc_pkg::usc_byte_t rdata,
  input wire logic ack
);
  import usc_pkg::*;
  // ========
  // Link timing and read values
  // ========
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  a_ack_after_strobe: assert property ((wr || rd) |=> ack)
    else $error("no ack one cycle after a strobe");
  a_ack_has_cause: assert property (ack |-> $past(wr || rd))
    else $error("ack without a strobe before it");
  a_strobe_single: assert property ((wr || rd) |=> !(wr || rd))
    else $error("strobe held past one cycle");
  a_strobe_exclusive: assert property (!(wr && rd))
    else $error("read and write strobes together");
  a_rdata_on_read: assert property ($changed(rdata) |-> ack && $past(rd))
    else $error("read data moved outside a read answer");
  a_unmapped_reads_zero: assert property (
    ack && $past(rd) && $past(idx) > IDX_STATUS |-> rdata == REG_RESET)
    else $error("unmapped index read nonzero");
  a_stall_upper_zero: assert property (
    ack && $past(rd) && ($past(idx) == IDX_OSTALL ||
    $past(idx) == IDX_ISTALL)
    |-> (rdata >> ENDPOINTS) == 8'h00)
    else $error("missing endpoint stall bit reads one");
  a_status_gap_zero: assert property (
    ack && $past(rd) && $past(idx) == IDX_STATUS |-> !rdata[5])
    else $error("unused status bit reads one");

  c_write_data: cover property (wr && wdata != 8'h00);
endmodule : usc_link_monitor
`default_nettype wire

/* File: sim/test_usb_sie_control_status.sv */
// Bench: APB controller and engine joined across the register link
`timescale 1ns/1ps
`default_nettype none
module test_usb_sie_control_status;
  import usc_pkg::*;
  typedef struct {usc_idx_t i; usc_byte_t w, r, o;} usc_row_t;
  // Six endpoints exercises both the fold of select codes and dead bits
  localparam int NUM_EP = 6;
  localparam int LIMIT = 20000;
  logic i_clock = 1'h0;
  logic i_sys_rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic setup_done = 1'h1, osc6 = 1'h0, in_tok = 1'h0;
  logic [9:0] ev = 10'h000;
  logic [15:0] flt = 16'h0000;
  logic pull, osc, pll, susp, clken, wake, nak_irq;
  logic [2:0] fifo;
  logic [6:0] addr;
  usc_byte_t out_stall, in_stall;
  int num_errors = 0, num_checks = 0, cycles = 0;
  usc_byte_t flg [6] = '{8'h40, 8'h40, 8'h40, 8'h10, 8'h02, 8'h04};
  usc_row_t rows [9] = '{
    '{IDX_CLKCTL, 8'h80, 8'h80, 8'h80},
    '{IDX_CLKCTL, 8'h20, 8'h20, 8'h20},
    '{IDX_CLKCTL, 8'h10, 8'h10, 8'h10},
    '{IDX_CLKCTL, 8'h08, 8'h08, 8'h08},
    '{IDX_CLKCTL, 8'hFF, 8'hBF, 8'hBD},
    '{IDX_ADDR, 8'hA5, 8'hA5, 8'hA5},
    '{IDX_OSTALL, 8'hFF, 8'h3F, 8'h3F},
    '{IDX_ISTALL, 8'hC3, 8'h03, 8'h03},
    '{3'h6, 8'h55, 8'h00, 8'h00}
  };

  // ========
  // Design and checker
  // ========
  usc_link_if u_usc_link_if ();
  usc_ctrl u_usc_ctrl (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_setup_token(ev[8]),
    .i_setup_stage_done(setup_done), .i_osc_is_6mhz(osc6),
    .link(u_usc_link_if));
  usc_device #(.ENDPOINTS(NUM_EP)) u_usc_device (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .link(u_usc_link_if), .i_usb_bus_reset(ev[9]),
    .i_setup_token(ev[8]), .i_in_token(in_tok), .i_out_data_token(ev[5]),
    .i_crc_error(ev[0]), .i_pid_error(ev[1]), .i_stuff_error(ev[2]),
    .i_no_response_error(ev[3]), .i_fifo_access_error(ev[4]),
    .i_nak_sent(ev[6]), .i_in_read_ok(ev[7]), .i_ep_out_fault(flt[15:8]),
    .i_ep_in_fault(flt[7:0]), .o_usb_data_plus_pullup(pull),
    .o_oscillator_freq_select(osc), .o_system_clock_from_pll(pll),
    .o_suspend_halt_enable(susp), .o_usb_engine_clock_enable(clken),
    .o_fifo_endpoint(fifo), .o_device_address(addr),
    .o_remote_wake_enable(wake), .o_nak_interrupt(nak_irq),
    .o_out_stall_bits(out_stall), .o_in_stall_bits(in_stall));
  usc_link_monitor #(.ENDPOINTS(NUM_EP)) u_usc_link_monitor (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .wr(u_usc_link_if.wr),
    .rd(u_usc_link_if.rd), .idx(u_usc_link_if.idx),
    .wdata(u_usc_link_if.wdata), .rdata(u_usc_link_if.rdata),
    .ack(u_usc_link_if.ack));

  // ========
  // Tasks
  // ========
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'h1;
    do @(posedge i_clock); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Polls busy so a new start is never refused
  task automatic idle(output logic [31:0] r);
    do apb(1'h0, OFS_STAT, 32'h00000000, r); while (r[STAT_BUSY] !== 1'h0);
  endtask : idle

  task automatic op(input logic w, input usc_idx_t i, input usc_byte_t d,
                    output usc_byte_t q);
    logic [31:0] r;
    apb(1'h1, OFS_CMD, {1'h1, 14'h0000, w, d, 5'h00, i}, r);
    idle(r);
    q = r[15:8];
  endtask : op

  // One-cycle event pulse; returns where flop outputs have settled
  task automatic fire(input logic [9:0] v, input logic [15:0] f = 16'h0000);
    @(posedge i_clock);
    ev <= v;
    flt <= f;
    @(posedge i_clock);
    ev <= 10'h000;
    flt <= 16'h0000;
    @(negedge i_clock);
  endtask : fire

  task automatic chk(input usc_byte_t got, input usc_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic usc_byte_t outs(input usc_idx_t i);
    case (i)
      IDX_CLKCTL: return {pull, osc, pll, susp, clken, fifo};
      IDX_ADDR: return {addr, wake};
      IDX_OSTALL: return out_stall;
      IDX_ISTALL: return in_stall;
      default: return 8'h00;
    endcase
  endfunction : outs

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ========
  // Clock, watchdog, sequence
  // ========
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    usc_byte_t q;
    logic [31:0] r;
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'h0;
    for (int k = 0; k < 5; k++) begin
      op(1'h0, usc_idx_t'(k), 8'h00, q);
      chk(q, REG_RESET);
    end
    foreach (rows[k]) begin
      op(1'h1, rows[k].i, rows[k].w, q);
      op(1'h0, rows[k].i, 8'h00, q);
      chk(q, rows[k].r);
      chk(outs(rows[k].i), rows[k].o);
    end
    for (int c = 0; c < 8; c++) begin
      op(1'h1, IDX_CLKCTL, 8'(c), q);
      chk({5'h00, fifo}, (c < 5) ? 8'(c) : 8'h05);
    end
    osc6 <= 1'h1;
    op(1'h1, IDX_CLKCTL, 8'h00, q);
    op(1'h0, IDX_CLKCTL, 8'h00, q);
    chk(q, 8'h40);
    osc6 <= 1'h0;
    in_tok <= 1'h1;
    op(1'h0, IDX_STATUS, 8'h00, q);
    chk(q, 8'h08);
    in_tok <= 1'h0;
    for (int k = 0; k < 6; k++) begin
      fire(10'(1 << k));
      op(1'h0, IDX_STATUS, 8'h00, q);
      chk(q, flg[k]);
      op(1'h1, IDX_STATUS, 8'h00, q);
      op(1'h0, IDX_STATUS, 8'h00, q);
      chk(q, 8'h00);
    end
    fire(10'h001);
    op(1'h1, IDX_STATUS, 8'h7E, q);
    op(1'h0, IDX_STATUS, 8'h00, q);
    chk(q, 8'h40);
    // Unmapped offset and a start while busy are both refused
    apb(1'h0, 8'h08, 32'h00000000, r);
    chk({7'h00, pslverr}, 8'h01);
    apb(1'h1, OFS_CMD, 32'h80010003, r);
    apb(1'h1, OFS_CMD, 32'h80010002, r);
    chk({7'h00, pslverr}, 8'h01);
    idle(r);
    op(1'h1, IDX_OSTALL, 8'h3F, q);
    op(1'h1, IDX_ISTALL, 8'h3F, q);
    op(1'h1, IDX_STATUS, 8'h00, q);
    fire(10'h020);
    fire(10'h100);
    chk(out_stall | in_stall, 8'h00);
    op(1'h0, IDX_STATUS, 8'h00, q);
    chk(q, 8'h00);
    fire(10'h000, 16'h0480);
    chk(out_stall, 8'h04);
    chk(in_stall, 8'h00);
    fire(10'h000, 16'h0008);
    chk(in_stall, 8'h08);
    fire(10'h200);
    chk(out_stall | in_stall, 8'h00);
    for (int m = 0; m < 2; m++) begin
      op(1'h1, IDX_STATUS, {m[0], 7'h00}, q);
      fire(10'h040);
      chk({7'h00, nak_irq}, {7'h00, ~m[0]});
    end
    op(1'h1, IDX_STATUS, 8'h01, q);
    setup_done <= 1'h0;
    apb(1'h1, OFS_CMD, 32'h80012201, r);
    apb(1'h0, OFS_STAT, 32'h00000000, r);
    chk(r[7:0], 8'h03);
    setup_done <= 1'h1;
    idle(r);
    chk({1'h0, addr}, 8'h52);
    fire(10'h080);
    @(negedge i_clock);
    chk({1'h0, addr}, 8'h11);
    fire(10'h100);
    op(1'h0, IDX_STATUS, 8'h00, q);
    chk(q, 8'h00);
    // Reset in mid-run must return address and controls to zero
    op(1'h1, IDX_CLKCTL, 8'hB8, q);
    i_sys_rst <= 1'h1;
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'h0;
    @(negedge i_clock);
    chk(outs(IDX_ADDR), REG_RESET);
    chk(outs(IDX_CLKCTL), REG_RESET);
    op(1'h0, IDX_ADDR, 8'h00, q);
    chk(q, REG_RESET);
    test_done();
  end
endmodule : test_usb_sie_control_status
`default_nettype wire
